/* File: src/dfcd_top.sv */
// Purpose: decode sense-condition and set-features commands
// Assumes: command block is stable while CMD_VALID_IN pulses; temperature input is
//          signed whole degrees plus a half-degree bit
// Notes: each command completes in one cycle; results persist until the next command
// What this block does
// - sense command needs feature 01h; any other feature aborts it.
// - sense result code 01h..FEh equals (code/2 - 20) degrees C.
// - temperature at or below -20 C reports 00h.
// - temperature above 107 C reports FFh.
// - lba low bit 0 reports overstress, else cleared.
// - sense command runs without spinning up the media.
// - out-of-range temperature may end sense with id-not-found set.
// - undefined set-features code sets abort in error register.
// - reset: cache, look-ahead, preservation on; revert, dipm off.
// - 02h enables write cache, 82h disables it.
// - 55h disables look-ahead, AAh enables it.
// - 66h stops reverting to defaults, CCh turns it on.
// - 03h loads transfer mode from sector count.
// - 05h enables power management, 85h disables it.
// - 06h/86h power-up in standby on/off; 07h requests spin-up.
// - 10h/90h enable/disable serial sub-feature chosen by sector count.
// - 41h/C1h free-fall control on/off, where sensor is fitted.
// - transfer mode: count bits 7:3 type, bits 2:0 mode.
// - apm level 01h..7Fh allows standby; 00h and FFh abort.
// - disabling power management leaves active idle as deepest state.
`timescale 1ns/10ps
module dfcd_top
  import dfcd_pkg::*;
#(
  parameter bit HAS_FREE_FALL = 1'b1
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // command block from host
  input wire logic CMD_VALID_IN,
  input wire dfcd_pkg::dfcd_cmd_t CMD_IN,
  // temperature sensor
  input wire logic signed [7:0] TEMP_C_IN,
  input wire logic TEMP_HALF_IN,
  input wire logic OVERSTRESS_IN,
  input wire logic TEMP_OOR_IN,
  // result registers
  output logic [7:0] ERROR_OUT,
  output logic [7:0] STATUS_OUT,
  output logic [7:0] COUNT_OUT,
  output logic [7:0] LBA_LOW_OUT,
  output logic DONE_OUT,
  // feature state and actions
  output dfcd_pkg::dfcd_feat_t FEAT_OUT,
  output logic SPIN_UP_OUT,
  output logic [4:0] XFER_TYPE_OUT,
  output logic [2:0] XFER_NUM_OUT
);
  import dfcd_pkg::*;

  localparam dfcd_feat_t FEAT_RESET = '{
    write_cache: 1'b1,
    look_ahead: 1'b1,
    revert_defaults: 1'b0,
    apm: 1'b0,
    puis: 1'b0,
    free_fall: 1'b0,
    nz_offset: 1'b0,
    auto_act: 1'b0,
    dipm: 1'b0,
    in_order: 1'b0,
    ssp: 1'b1,
    deepest: DFCD_PWR_ACTIDLE,
    xfer_mode: XFER_RESET,
    apm_level: APM_RESET,
    ff_sense: FF_RESET
  };

  // registers behind the result ports
  logic [7:0] error_flags;
  logic [7:0] device_status_flags;
  logic [7:0] count_r;
  logic [7:0] lba_low_r;
  logic done_r;
  logic spin_r;
  // feature settings
  dfcd_feat_t feat;

  // next values, one set per state group
  logic [7:0] next_error_flags;
  logic [7:0] next_device_status_flags;
  logic [7:0] next_count_r;
  logic [7:0] next_lba_low_r;
  logic next_done_r;
  logic next_spin_r;
  dfcd_feat_t next_feat;

  // temperature to code; full signed range checked before the shift
  function automatic logic [7:0] temp_code(input logic signed [7:0] t, input logic half);
    logic signed [9:0] c;
    c = 10'(signed'(t)) + 10'sd20;
    // a half degree above -20 already reports 01h
    if (t < 8'(TEMP_MIN_C) || (t == 8'(TEMP_MIN_C) && !half)) begin
      temp_code = TEMP_LOW_CODE;
    end else if (t > 8'(TEMP_MAX_C) || (t == 8'(TEMP_MAX_C) && half)) begin
      temp_code = TEMP_HIGH_CODE;
    end else begin
      temp_code = {c[6:0], half};
    end
  endfunction

  function automatic dfcd_pwr_t apm_deepest(input logic [7:0] lvl);
    if (lvl <= APM_STBY_MAX) begin
      apm_deepest = DFCD_PWR_STANDBY;
    end else if (lvl <= APM_LPI_MAX) begin
      apm_deepest = DFCD_PWR_LPIDLE;
    end else begin
      apm_deepest = DFCD_PWR_ACTIDLE;
    end
  endfunction

  // command classification, shared by every state group below
  logic is_sense;
  logic is_setf;
  logic sense_ok;
  logic abort;
  logic idnf;

  // serial sub-feature selectors this block knows; any other one is undefined
  function automatic logic ser_known(input logic [7:0] sel);
    ser_known = (sel == SER_OFFSET) || (sel == SER_AUTOACT) || (sel == SER_DIPM) ||
      (sel == SER_INORDER) || (sel == SER_SSP);
  endfunction

  // whether a set-features request is carried out or refused with abort
  function automatic logic setf_accepted(input logic [7:0] code, input logic [7:0] cnt);
    case (code)
      FC_WC_EN, FC_WC_DIS: setf_accepted = 1'b1;
      FC_RLA_DIS, FC_RLA_EN: setf_accepted = 1'b1;
      FC_REV_DIS, FC_REV_EN: setf_accepted = 1'b1;
      FC_XFER: setf_accepted = 1'b1;
      FC_APM_DIS: setf_accepted = 1'b1;
      FC_PUIS_EN, FC_PUIS_DIS: setf_accepted = 1'b1;
      FC_PUIS_SPIN: setf_accepted = 1'b1;
      // levels at either end of the range are refused and leave the state alone
      FC_APM_EN: setf_accepted = (cnt != APM_BAD_LO) && (cnt != APM_BAD_HI);
      FC_SER_EN, FC_SER_DIS: setf_accepted = ser_known(cnt);
      // without a sensor the free-fall codes count as undefined
      FC_FF_EN, FC_FF_DIS: setf_accepted = HAS_FREE_FALL;
      default: setf_accepted = 1'b0;
    endcase
  endfunction

  always_comb begin
    is_sense = CMD_VALID_IN && (CMD_IN.command == CMD_SENSE);
    is_setf = CMD_VALID_IN && (CMD_IN.command == CMD_SETFEAT);
    sense_ok = 1'b0;
    abort = 1'b0;
    idnf = 1'b0;
    if (is_sense) begin
      if (CMD_IN.feature != SENSE_FEAT) begin
        abort = 1'b1;
      end else if (TEMP_OOR_IN) begin
        // count and lba low keep their old contents on this error
        idnf = 1'b1;
      end else begin
        sense_ok = 1'b1;
      end
    end else if (is_setf) begin
      abort = !setf_accepted(CMD_IN.feature, CMD_IN.count);
    end else if (CMD_VALID_IN) begin
      // an opcode outside this block is refused, never silently dropped
      abort = 1'b1;
    end
  end

  // sense data group: kept from the last good sense until the next one
  always_comb begin
    next_count_r = count_r;
    next_lba_low_r = lba_low_r;
    if (sense_ok) begin
      next_count_r = temp_code(TEMP_C_IN, TEMP_HALF_IN);
      next_lba_low_r = {7'h00, OVERSTRESS_IN};
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      count_r <= 8'h00;
      lba_low_r <= 8'h00;
    end else begin
      count_r <= next_count_r;
      lba_low_r <= next_lba_low_r;
    end
  end

  // completion group: error and status are rewritten by every command
  always_comb begin
    next_error_flags = error_flags;
    next_device_status_flags = device_status_flags;
    if (CMD_VALID_IN) begin
      next_error_flags = 8'h00;
      next_error_flags[ERR_ABT] = abort;
      next_error_flags[ERR_IDN] = idnf;
      next_device_status_flags = 8'h00;
      next_device_status_flags[ST_RDY] = 1'b1;
      next_device_status_flags[ST_DSC] = 1'b1;
      next_device_status_flags[ST_BSY] = 1'b0;
      next_device_status_flags[ST_ERR] = abort | idnf;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      error_flags <= 8'h00;
      device_status_flags <= STATUS_RESET;
    end else begin
      error_flags <= next_error_flags;
      device_status_flags <= next_device_status_flags;
    end
  end

  // pulse group: both strobes stand one cycle for each command cycle that raises them
  always_comb begin
    next_done_r = CMD_VALID_IN;
    // sensing never raises the spin-up strobe, so the media stays still
    next_spin_r = is_setf && !abort && (CMD_IN.feature == FC_PUIS_SPIN);
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      done_r <= 1'b0;
      spin_r <= 1'b0;
    end else begin
      done_r <= next_done_r;
      spin_r <= next_spin_r;
    end
  end

  // feature group: settings change only on an accepted set-features request
  always_comb begin
    next_feat = feat;
    if (is_setf && !abort) begin
      case (CMD_IN.feature)
        FC_WC_EN: next_feat.write_cache = 1'b1;
        FC_WC_DIS: next_feat.write_cache = 1'b0;
        FC_RLA_DIS: next_feat.look_ahead = 1'b0;
        FC_RLA_EN: next_feat.look_ahead = 1'b1;
        FC_REV_DIS: next_feat.revert_defaults = 1'b0;
        FC_REV_EN: next_feat.revert_defaults = 1'b1;
        FC_XFER: next_feat.xfer_mode = CMD_IN.count;
        FC_APM_EN: begin
          next_feat.apm = 1'b1;
          next_feat.apm_level = CMD_IN.count;
          next_feat.deepest = apm_deepest(CMD_IN.count);
        end
        FC_APM_DIS: begin
          next_feat.apm = 1'b0;
          next_feat.deepest = DFCD_PWR_ACTIDLE;
        end
        FC_PUIS_EN: next_feat.puis = 1'b1;
        FC_PUIS_DIS: next_feat.puis = 1'b0;
        FC_SER_EN, FC_SER_DIS: begin
          // the sector count picks the sub-feature
          if (CMD_IN.count == SER_OFFSET) begin
            next_feat.nz_offset = (CMD_IN.feature == FC_SER_EN);
          end else if (CMD_IN.count == SER_AUTOACT) begin
            next_feat.auto_act = (CMD_IN.feature == FC_SER_EN);
          end else if (CMD_IN.count == SER_DIPM) begin
            next_feat.dipm = (CMD_IN.feature == FC_SER_EN);
          end else if (CMD_IN.count == SER_INORDER) begin
            next_feat.in_order = (CMD_IN.feature == FC_SER_EN);
          end else if (CMD_IN.count == SER_SSP) begin
            next_feat.ssp = (CMD_IN.feature == FC_SER_EN);
          end
        end
        FC_FF_EN, FC_FF_DIS: begin
          next_feat.free_fall = (CMD_IN.feature == FC_FF_EN);
          // the sensitivity is only loaded by the enable code
          if (CMD_IN.feature == FC_FF_EN) begin
            next_feat.ff_sense = CMD_IN.count;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      feat <= FEAT_RESET;
    end else begin
      feat <= next_feat;
    end
  end

  assign ERROR_OUT = error_flags;
  assign STATUS_OUT = device_status_flags;
  assign COUNT_OUT = count_r;
  assign LBA_LOW_OUT = lba_low_r;
  assign DONE_OUT = done_r;
  assign FEAT_OUT = feat;
  assign SPIN_UP_OUT = spin_r;
  assign XFER_TYPE_OUT = feat.xfer_mode[7:3];
  assign XFER_NUM_OUT = feat.xfer_mode[2:0];
endmodule

/* File: pkg/dfcd_pkg.sv */
// Purpose: constants and carrier types for the drive feature command decoder
// Assumes: task-file registers are 8 bits wide
// Notes: status and error bit positions follow the task-file layout
package dfcd_pkg;
  // command opcodes
  localparam logic [7:0] CMD_SENSE = 8'hf0;
  localparam logic [7:0] CMD_SETFEAT = 8'hef;
  localparam logic [7:0] SENSE_FEAT = 8'h01;
  // feature codes
  localparam logic [7:0] FC_WC_EN = 8'h02;
  localparam logic [7:0] FC_XFER = 8'h03;
  localparam logic [7:0] FC_APM_EN = 8'h05;
  localparam logic [7:0] FC_PUIS_EN = 8'h06;
  localparam logic [7:0] FC_PUIS_SPIN = 8'h07;
  localparam logic [7:0] FC_SER_EN = 8'h10;
  localparam logic [7:0] FC_FF_EN = 8'h41;
  localparam logic [7:0] FC_RLA_DIS = 8'h55;
  localparam logic [7:0] FC_REV_DIS = 8'h66;
  localparam logic [7:0] FC_WC_DIS = 8'h82;
  localparam logic [7:0] FC_APM_DIS = 8'h85;
  localparam logic [7:0] FC_PUIS_DIS = 8'h86;
  localparam logic [7:0] FC_SER_DIS = 8'h90;
  localparam logic [7:0] FC_RLA_EN = 8'haa;
  localparam logic [7:0] FC_FF_DIS = 8'hc1;
  localparam logic [7:0] FC_REV_EN = 8'hcc;
  // serial sub-feature selectors
  localparam logic [7:0] SER_OFFSET = 8'h01;
  localparam logic [7:0] SER_AUTOACT = 8'h02;
  localparam logic [7:0] SER_DIPM = 8'h03;
  localparam logic [7:0] SER_INORDER = 8'h04;
  localparam logic [7:0] SER_SSP = 8'h06;
  // apm levels
  localparam logic [7:0] APM_STBY_MAX = 8'h7f;
  localparam logic [7:0] APM_LPI_MAX = 8'hbf;
  localparam logic [7:0] APM_BAD_LO = 8'h00;
  localparam logic [7:0] APM_BAD_HI = 8'hff;
  // temperature code limits, code = 2*(t+20)
  localparam logic [7:0] TEMP_LOW_CODE = 8'h00;
  localparam logic [7:0] TEMP_HIGH_CODE = 8'hff;
  localparam int TEMP_MIN_C = -20;
  localparam int TEMP_MAX_C = 107;
  // error and status bit positions
  localparam int ERR_IDN = 4;
  localparam int ERR_ABT = 2;
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_ERR = 0;
  // reset values
  localparam logic [7:0] XFER_RESET = 8'h00;
  localparam logic [7:0] APM_RESET = 8'h80;
  localparam logic [7:0] FF_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h50;

  typedef enum logic [1:0] {
    DFCD_PWR_STANDBY = 2'b00,
    DFCD_PWR_LPIDLE = 2'b01,
    DFCD_PWR_ACTIDLE = 2'b10
  } dfcd_pwr_t;

  // host-written command block
  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] count;
    logic [7:0] command;
  } dfcd_cmd_t;

  // feature settings held by the device
  typedef struct packed {
    logic write_cache;
    logic look_ahead;
    logic revert_defaults;
    logic apm;
    logic puis;
    logic free_fall;
    logic nz_offset;
    logic auto_act;
    logic dipm;
    logic in_order;
    logic ssp;
    dfcd_pwr_t deepest;
    logic [7:0] xfer_mode;
    logic [7:0] apm_level;
    logic [7:0] ff_sense;
  } dfcd_feat_t;
endpackage

/* File: test/dfcd_assertions.sv */
// Purpose: port checks for the feature command decoder
// Assumes: one clock, asynchronous active-low reset
// Notes: results are judged one edge after the command is taken
`timescale 1ns/10ps
module dfcd_assertions
  import dfcd_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  // command and sensor
  input wire logic CMD_VALID_IN,
  input wire dfcd_pkg::dfcd_cmd_t CMD_IN,
  input wire logic signed [7:0] TEMP_C_IN,
  input wire logic TEMP_HALF_IN,
  input wire logic OVERSTRESS_IN,
  input wire logic TEMP_OOR_IN,
  // results
  input wire logic [7:0] ERROR_OUT,
  input wire logic [7:0] STATUS_OUT,
  input wire logic [7:0] COUNT_OUT,
  input wire logic [7:0] LBA_LOW_OUT,
  input wire logic DONE_OUT,
  input wire dfcd_pkg::dfcd_feat_t FEAT_OUT,
  input wire logic SPIN_UP_OUT,
  input wire logic [4:0] XFER_TYPE_OUT,
  input wire logic [2:0] XFER_NUM_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  logic sense;
  logic setf;
  logic ok;
  logic low;
  logic high;
  assign sense = CMD_VALID_IN && CMD_IN.command == CMD_SENSE;
  assign setf = CMD_VALID_IN && CMD_IN.command == CMD_SETFEAT;
  assign ok = sense && CMD_IN.feature == SENSE_FEAT && !TEMP_OOR_IN;
  // half-degree bit decides the boundary cases at -20 and 107
  assign low = TEMP_C_IN < -20 || (TEMP_C_IN == -20 && !TEMP_HALF_IN);
  assign high = TEMP_C_IN > 107 || (TEMP_C_IN == 107 && TEMP_HALF_IN);
  property p_sabt; sense && CMD_IN.feature != SENSE_FEAT |=> ERROR_OUT[ERR_ABT] && STATUS_OUT[ST_ERR]; endproperty
  a_sabt: assert property (p_sabt) else $error("sense abort missing");
  property p_code; ok && !low && !high |=> COUNT_OUT == 8'(2 * $past(TEMP_C_IN) + 40 + $past(TEMP_HALF_IN)); endproperty
  a_code: assert property (p_code) else $error("temperature code wrong");
  property p_low; ok && low |=> COUNT_OUT == TEMP_LOW_CODE; endproperty
  a_low: assert property (p_low) else $error("low clamp wrong");
  property p_high; ok && high |=> COUNT_OUT == TEMP_HIGH_CODE; endproperty
  a_high: assert property (p_high) else $error("high clamp wrong");
  property p_stress; ok |=> LBA_LOW_OUT[0] == $past(OVERSTRESS_IN); endproperty
  a_stress: assert property (p_stress) else $error("overstress bit wrong");
  property p_nospin; sense |=> !SPIN_UP_OUT; endproperty
  a_nospin: assert property (p_nospin) else $error("sense spun up");
  property p_oor; sense && CMD_IN.feature == SENSE_FEAT && TEMP_OOR_IN |=> ERROR_OUT[ERR_IDN]; endproperty
  a_oor: assert property (p_oor) else $error("range error missing");
  property p_wc; setf && CMD_IN.feature[6:0] == 7'h02 |=> FEAT_OUT.write_cache == !$past(CMD_IN.feature[7]); endproperty
  a_wc: assert property (p_wc) else $error("write cache wrong");
  property p_xfer; setf && CMD_IN.feature == FC_XFER |=> {XFER_TYPE_OUT, XFER_NUM_OUT} == $past(CMD_IN.count); endproperty
  a_xfer: assert property (p_xfer) else $error("transfer mode wrong");
  property p_apm; setf && CMD_IN.feature == FC_APM_DIS |=> FEAT_OUT.deepest == DFCD_PWR_ACTIDLE; endproperty
  a_apm: assert property (p_apm) else $error("deepest state wrong");
  property p_err; DONE_OUT && (ERROR_OUT[ERR_ABT] || ERROR_OUT[ERR_IDN]) |-> STATUS_OUT[ST_ERR] && !STATUS_OUT[ST_BSY];
  endproperty
  a_err: assert property (p_err) else $error("status error bit wrong");
endmodule

/* File: test/dfcd_host_model.sv */
// Purpose: host side writing the command block
// Assumes: commands change on falling edges
// Notes: released command lines show inverted values, never stale ones
`timescale 1ns/10ps
module dfcd_host_model
  import dfcd_pkg::*;
(
  // clock and completion
  input wire logic clk_in,
  input wire logic done_in,
  // command block
  output logic cmd_valid_out,
  output dfcd_pkg::dfcd_cmd_t cmd_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end
  task issue(input dfcd_cmd_t a, input dfcd_cmd_t b = '0, input bit two = 1'b0, input int gap = 0);
    repeat (gap) @(negedge clk_in);
    @(negedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_out <= a;
    if (two) begin
      @(negedge clk_in);
      cmd_out <= b;
    end
    @(negedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_out <= ~cmd_out;
    for (int i = 0; i < 4 && done_in !== 1'b1; i++) @(negedge clk_in);
  endtask
endmodule

/* File: test/dfcd_top_tb.sv */
// Purpose: self-checking bench for the feature command decoder
// Assumes: host model issues commands; sensor inputs set here
// Notes: expected feature state is tracked in e
`timescale 1ns/10ps
module dfcd_top_tb;
  import dfcd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cv, half = 1'b0, stress = 1'b0, oor = 1'b0, done, spin;
  logic signed [7:0] temp = '0;
  logic [7:0] err, sta, cnt, lba;
  logic [4:0] xt;
  logic [2:0] xn;
  dfcd_cmd_t cmd;
  dfcd_feat_t feat, e;
  int err_count = 0;
  int comparisons = 0;
  int spins = 0;
  always #2 clk = ~clk;
  always @(negedge clk) if (spin === 1'b1) spins++;
  dfcd_host_model i_host (.clk_in(clk), .done_in(done), .cmd_valid_out(cv), .cmd_out(cmd));
  dfcd_top i_dut (.CLK_IN(clk), .RSTN_IN(rstn), .CMD_VALID_IN(cv), .CMD_IN(cmd), .TEMP_C_IN(temp),
    .TEMP_HALF_IN(half), .OVERSTRESS_IN(stress), .TEMP_OOR_IN(oor), .ERROR_OUT(err), .STATUS_OUT(sta),
    .COUNT_OUT(cnt), .LBA_LOW_OUT(lba), .DONE_OUT(done), .FEAT_OUT(feat), .SPIN_UP_OUT(spin),
    .XFER_TYPE_OUT(xt), .XFER_NUM_OUT(xn));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task t_reset;
    e = '0;
    e.write_cache = 1'b1;
    e.look_ahead = 1'b1;
    e.ssp = 1'b1;
    e.deepest = DFCD_PWR_ACTIDLE;
    e.apm_level = 8'h80;
    chk(feat, e);
    chk({err, sta}, 16'h0050);
    $display("reset test done");
  endtask
  task t_sense;
    logic signed [7:0] tv[7] = '{-21, -20, -20, 25, 107, 107, 120};
    logic [7:0] ev[7] = '{8'h00, 8'h00, 8'h01, 8'h5a, 8'hfe, 8'hff, 8'hff};
    for (int i = 0; i < 7; i++) begin
      temp = tv[i];
      half = (i == 2 || i == 5);
      stress = i[0];
      i_host.issue({SENSE_FEAT, 8'h00, CMD_SENSE}, '0, 1'b0, i[1:0]);
      chk(cnt, ev[i]);
      chk({lba[0], sta}, {i[0], 8'h50});
    end
    chk(spins, 0);
    $display("sense test done");
  endtask
  task t_err;
    i_host.issue({8'h02, 8'h00, CMD_SENSE});
    chk({done, err[ERR_ABT], sta[ST_ERR], sta[ST_BSY]}, 4'b1110);
    oor = 1'b1;
    i_host.issue({SENSE_FEAT, 8'h00, CMD_SENSE});
    chk({err[ERR_IDN], sta[ST_ERR]}, 2'b11);
    oor = 1'b0;
    i_host.issue({8'h00, 8'h00, CMD_SETFEAT});
    chk({err[ERR_ABT], sta[ST_ERR]}, 2'b11);
    i_host.issue({FC_APM_EN, APM_BAD_HI, CMD_SETFEAT});
    chk({err[ERR_ABT], feat}, {1'b1, e});
    $display("error test done");
  endtask
  task t_feat;
    logic [15:0] w[17] = '{16'h8200, 16'h0200, 16'h5500, 16'haa00, 16'hcc00, 16'h6600, 16'h0540, 16'h8500,
      16'h0600, 16'h0700, 16'h8600, 16'h1003, 16'h9003, 16'h9006, 16'h4120, 16'hc100, 16'h0345};
    for (int i = 0; i < 17; i++) begin
      i_host.issue({w[i], CMD_SETFEAT});
      case (w[i])
        16'h8200: e.write_cache = 1'b0;
        16'h0200: e.write_cache = 1'b1;
        16'h5500: e.look_ahead = 1'b0;
        16'haa00: e.look_ahead = 1'b1;
        16'hcc00: e.revert_defaults = 1'b1;
        16'h6600: e.revert_defaults = 1'b0;
        16'h0540: begin
          e.apm = 1'b1;
          e.apm_level = 8'h40;
          e.deepest = DFCD_PWR_STANDBY;
        end
        16'h8500: begin
          e.apm = 1'b0;
          e.deepest = DFCD_PWR_ACTIDLE;
        end
        16'h0600: e.puis = 1'b1;
        16'h8600: e.puis = 1'b0;
        16'h1003: e.dipm = 1'b1;
        16'h9003: e.dipm = 1'b0;
        16'h9006: e.ssp = 1'b0;
        16'h4120: e.ff_sense = 8'h20;
        16'h0345: e.xfer_mode = 8'h45;
        default: ;
      endcase
      e.free_fall = w[i] == 16'h4120 || (e.free_fall && w[i] != 16'hc100);
      chk({done, feat, err, sta}, {1'b1, e, 16'h0050});
    end
    chk(spins, 1);
    chk({xt, xn}, 8'h45);
    i_host.issue({FC_WC_DIS, 8'h00, CMD_SETFEAT}, {FC_RLA_DIS, 8'h00, CMD_SETFEAT}, 1'b1);
    chk({feat.write_cache, feat.look_ahead}, 2'b00);
    $display("feature test done");
  endtask
  initial begin
    #20000;
    err_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report;
  end
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_reset;
    t_sense;
    t_err;
    t_feat;
    final_report;
  end
endmodule
bind dfcd_top dfcd_assertions i_chk (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .CMD_VALID_IN(CMD_VALID_IN),
  .CMD_IN(CMD_IN), .TEMP_C_IN(TEMP_C_IN), .TEMP_HALF_IN(TEMP_HALF_IN), .OVERSTRESS_IN(OVERSTRESS_IN),
  .TEMP_OOR_IN(TEMP_OOR_IN), .ERROR_OUT(ERROR_OUT), .STATUS_OUT(STATUS_OUT), .COUNT_OUT(COUNT_OUT),
  .LBA_LOW_OUT(LBA_LOW_OUT), .DONE_OUT(DONE_OUT), .FEAT_OUT(FEAT_OUT), .SPIN_UP_OUT(SPIN_UP_OUT),
  .XFER_TYPE_OUT(XFER_TYPE_OUT), .XFER_NUM_OUT(XFER_NUM_OUT));
